// [e_clock_gen.sv]
// divide-by-four bus clock generator
`timescale 1ns/100ps
module e_clock_gen
  import port3_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  output logic [1:0]      e_phase,
  output logic            e_clk
);

  wire logic [1:0] next_phase = e_phase + 2'h1;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      e_phase <= 2'h0;
      e_clk   <= 1'b0;
    end
    else if (clk_en)
    begin
      e_phase <= next_phase;
      e_clk   <= (next_phase >= E_HIGH_PHASE);
    end
  end

endmodule // e_clock_gen

// [mode_strap.sv]
// operating mode capture from the mode pins
`timescale 1ns/100ps
module mode_strap
  import port3_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [2:0] mode_pins,
  output logic [2:0]      mode
);

  // sync reset: pins follow during reset, last value before release is kept
  always_ff @(posedge clk_sys)
  begin
    if (rst && clk_en)
      mode <= mode_pins;
  end

endmodule // mode_strap

// [port3_asserts.sv]
// concurrent checks on the strobed parallel port pins
`timescale 1ns/100ps
module port3_asserts
  import port3_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [2:0]        mode,
  input wire logic [15:0]       ext_addr,
  input wire logic              e_clk,
  input wire logic [WIDTH-1:0]  port_out,
  input wire logic [WIDTH-1:0]  port_oe_n,
  input wire logic              strobe_ctl_first_in,
  input wire logic              strobe_ctl_first_out,
  input wire logic              strobe_ctl_first_oe_n,
  input wire logic              strobe_ctl_second_out,
  input wire logic              maskable_request_one_n
);
  // -----------------------------------------------
  // shadow of the control bits written over apb
  // -----------------------------------------------
  logic oss_q;
  logic irq_en_q;
  wire  done_w = psel && penable && pready && !pslverr;
  wire  single = mode == MODE_SINGLE || mode == MODE_SINGLE_TEST;
  wire  nonmux = mode == MODE_NONMUX;
  wire  muxed  = !single && !nonmux;
  wire  os_hit = single && done_w && paddr == DATA_ADDR && pwrite == oss_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      oss_q    <= 1'b0;
      irq_en_q <= 1'b0;
    end
    else if (clk_en && done_w && pwrite && paddr == CSR_ADDR)
    begin
      oss_q    <= pwdata[CSR_OSS_BIT];
      irq_en_q <= pwdata[CSR_IRQ_BIT];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  // a frozen clock enable disables the checks and abandons every attempt in flight
  default disable iff (rst || !clk_en);
  e_div_a: assert property ($rose(e_clk) |=> e_clk ##1 !e_clk ##1 !e_clk ##1 e_clk)
    else $error("bus clock period wrong");
  sc1_dir_a: assert property (!$past(rst) |-> strobe_ctl_first_oe_n == single)
    else $error("first strobe pin direction wrong");
  os_pulse_a: assert property (os_hit |=> !strobe_ctl_second_out [*4] ##1 strobe_ctl_second_out)
    else $error("output strobe width wrong");
  os_cause_a: assert property (single && $fell(strobe_ctl_second_out) |-> $past(os_hit))
    else $error("output strobe without cause");
  ios_win_a: assert property (nonmux && $fell(strobe_ctl_first_out) |->
    ext_addr >= IO_WIN_LO && ext_addr <= IO_WIN_HI)
    else $error("io select outside window");
  as_addr_a: assert property (muxed && $fell(strobe_ctl_first_out) &&
    !$past(strobe_ctl_first_oe_n) |->
    $past(port_out) == ext_addr[7:0])
    else $error("address not on port at strobe fall");
  as_float_a: assert property (muxed && $fell(strobe_ctl_first_out) |-> &port_oe_n)
    else $error("port driven between address and data");
  rw_dir_a: assert property (nonmux && strobe_ctl_second_out |-> &port_oe_n)
    else $error("port driven during read");
  irq_mask_a: assert property (!single || (!irq_en_q && !$past(irq_en_q)) |->
    maskable_request_one_n)
    else $error("request not inhibited");
  irq_raise_a: assert property (single && irq_en_q && $fell(strobe_ctl_first_in) |->
    ##[1:3] !maskable_request_one_n)
    else $error("request missing after input strobe");
  reset_out_a: assert property ($past(rst) |->
    maskable_request_one_n && strobe_ctl_second_out && !pready)
    else $error("outputs not idle after reset");
endmodule // port3_asserts

bind port3_strobed_parallel_port port3_asserts #(.WIDTH(WIDTH)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .mode(mode),
  .ext_addr(ext_addr), .e_clk(e_clk), .port_out(port_out), .port_oe_n(port_oe_n),
  .strobe_ctl_first_in(strobe_ctl_first_in), .strobe_ctl_first_out(strobe_ctl_first_out),
  .strobe_ctl_first_oe_n(strobe_ctl_first_oe_n),
  .strobe_ctl_second_out(strobe_ctl_second_out),
  .maskable_request_one_n(maskable_request_one_n));

// [port3_peer.sv]
// far-side peripheral model for the strobed parallel port
`timescale 1ns/100ps
module port3_peer
  import port3_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [2:0] mode,
  input  wire logic       e_clk,
  input  wire logic       rw,
  input  wire logic [7:0] port_oe_n,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] line_data,
  input  wire logic       strobe_go,
  output logic [7:0]      port_in,
  output logic            strobe_in,
  output logic [7:0]      wr_seen
);
  logic [7:0] last = 8'h00;
  logic [3:0] cnt  = 4'h0;
  wire        single = mode == MODE_SINGLE || mode == MODE_SINGLE_TEST;
  initial wr_seen = 8'h00;
  // released bus toggles so stale data never passes for an answer
  assign port_in   = single || (rw && e_clk && &port_oe_n) ? line_data : ~last;
  assign strobe_in = cnt == 4'h0;
  always @(posedge clk_sys)
  begin
    last <= port_in;
    cnt  <= strobe_go ? 4'h8 : cnt - 4'(cnt != 4'h0);
    if (!rw && e_clk && port_oe_n == 8'h00)
      wr_seen <= port_out;
  end
endmodule // port3_peer

// [port3_pkg.sv]
// constants, types and register map of the strobed parallel port
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package port3_pkg;

  // ---------------------------------------------------------------
  // bus clock
  // ---------------------------------------------------------------
  localparam int         E_DIV            = 4;
  localparam logic [1:0] E_LAST_PHASE     = 2'h3;
  localparam logic [1:0] E_HIGH_PHASE     = 2'h2;
  localparam int         OS_LOW_E_PERIODS = 1;
  localparam logic [2:0] OS_LOW_CYCLES    = 3'(E_DIV * OS_LOW_E_PERIODS);

  // ---------------------------------------------------------------
  // register map: printed indices, byte address is four times index
  // ---------------------------------------------------------------
  localparam int         APB_AW    = 10;
  localparam logic [7:0] DDR_IDX   = 8'h04;
  localparam logic [7:0] DATA_IDX  = 8'h06;
  localparam logic [7:0] CSR_IDX   = 8'h0f;
  localparam logic [7:0] MODE_IDX  = 8'h18;
  localparam logic [APB_AW-1:0] DDR_ADDR  = {DDR_IDX, 2'b00};
  localparam logic [APB_AW-1:0] DATA_ADDR = {DATA_IDX, 2'b00};
  localparam logic [APB_AW-1:0] CSR_ADDR  = {CSR_IDX, 2'b00};
  localparam logic [APB_AW-1:0] MODE_ADDR = {MODE_IDX, 2'b00};

  localparam int CSR_LATCH_BIT = 3;
  localparam int CSR_OSS_BIT   = 4;
  localparam int CSR_IRQ_BIT   = 6;
  localparam int CSR_FLAG_BIT  = 7;

  localparam logic [7:0] DDR_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ---------------------------------------------------------------
  // expanded bus
  // ---------------------------------------------------------------
  localparam logic [15:0] IO_WIN_LO = 16'h0100;
  localparam logic [15:0] IO_WIN_HI = 16'h01ff;

  localparam logic [2:0] MODE_SINGLE      = 3'h7;
  localparam logic [2:0] MODE_SINGLE_TEST = 3'h4;
  localparam logic [2:0] MODE_NONMUX      = 3'h5;
  localparam logic [2:0] MODE_RESET       = 3'h7;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_GAP  = 2'b10,
    BUS_DATA = 2'b11
  } bus_state_t;

endpackage

// [port3_strobed_parallel_port.sv]
// strobed parallel port with APB register access and expanded bus modes
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module port3_strobed_parallel_port
  import port3_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // mode pins
  input  wire logic              mode_pin_zero,
  input  wire logic              mode_pin_one,
  input  wire logic              mode_pin_two,
  output logic [2:0]             mode,
  // expanded bus requests from the core side
  input  wire logic              ext_req,
  input  wire logic              ext_write,
  input  wire logic [15:0]       ext_addr,
  input  wire logic [WIDTH-1:0]  ext_wdata,
  output logic [WIDTH-1:0]       ext_rdata,
  output logic                   ext_done,
  // pins
  output logic                   e_clk,
  input  wire logic [WIDTH-1:0]  port_in,
  output logic [WIDTH-1:0]       port_out,
  output logic [WIDTH-1:0]       port_oe_n,
  input  wire logic              strobe_ctl_first_in,
  output logic                   strobe_ctl_first_out,
  output logic                   strobe_ctl_first_oe_n,
  output logic                   strobe_ctl_second_out,
  output logic                   maskable_request_one_n
);

  // ---------------------------------------------------------------
  // bus clock and mode
  // ---------------------------------------------------------------
  logic [1:0] e_phase;

  e_clock_gen u_eclk (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_en  (clk_en),
    .e_phase (e_phase),
    .e_clk   (e_clk)
  );

  mode_strap u_mode (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .mode_pins ({mode_pin_two, mode_pin_one, mode_pin_zero}),
    .mode      (mode)
  );

  wire logic single = (mode == MODE_SINGLE) || (mode == MODE_SINGLE_TEST);
  wire logic nonmux = (mode == MODE_NONMUX);
  wire logic e_end  = (e_phase == E_LAST_PHASE);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic             latch_enable;
  logic             strobe_select_bit;
  logic             strobe_irq_on;
  logic             strobe_seen_flag;
  logic             flag_armed;
  logic             latch_held;
  logic [WIDTH-1:0] ddr;
  logic [WIDTH-1:0] data_out;
  logic [WIDTH-1:0] latch_data;
  logic             strobe_in_q;
  logic [2:0]       os_count;

  wire logic xfer     = psel && penable && pready;
  wire logic hit_ddr  = (paddr == DDR_ADDR);
  wire logic hit_data = (paddr == DATA_ADDR);
  wire logic hit_csr  = (paddr == CSR_ADDR);
  wire logic hit_mode = (paddr == MODE_ADDR);
  wire logic hit_any  = hit_ddr || hit_data || hit_csr || hit_mode;

  wire logic wr_ddr   = xfer && pwrite && hit_ddr;
  wire logic wr_data  = xfer && pwrite && hit_data;
  wire logic wr_csr   = xfer && pwrite && hit_csr;
  wire logic rd_data  = xfer && !pwrite && hit_data;
  wire logic rd_csr   = xfer && !pwrite && hit_csr;
  wire logic acc_data = wr_data || rd_data;

  // input lines read the latch while it holds, else the live pins
  wire logic [WIDTH-1:0] in_view   = latch_held ? latch_data : port_in;
  wire logic [WIDTH-1:0] data_view = (ddr & data_out) | (~ddr & in_view);

  wire logic [7:0] csr_view = {strobe_seen_flag, strobe_irq_on, 1'b0,
                               strobe_select_bit, latch_enable, 3'b000};

  wire logic [31:0] next_prdata =
      hit_ddr  ? {{(32-WIDTH){1'b0}}, ddr} :
      hit_data ? {{(32-WIDTH){1'b0}}, data_view} :
      hit_csr  ? {24'h000000, csr_view} :
      hit_mode ? {29'h0, mode} : 32'h0;

  // one wait state so that read data leaves a flop
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0;
      pslverr <= psel && penable && !pready && !hit_any;
    end
  end

  // ---------------------------------------------------------------
  // port registers, latch and strobe flag
  // ---------------------------------------------------------------
  wire logic strobe_fall = single && strobe_in_q && !strobe_ctl_first_in;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ddr      <= DDR_RESET;
      data_out <= DATA_RESET;
    end
    else if (clk_en)
    begin
      if (wr_ddr)
        ddr <= pwdata[WIDTH-1:0];
      if (wr_data)
        data_out <= pwdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      latch_enable      <= 1'b0;
      strobe_select_bit <= 1'b0;
      strobe_irq_on     <= 1'b0;
    end
    else if (clk_en && wr_csr)
    begin
      latch_enable      <= pwdata[CSR_LATCH_BIT];
      strobe_select_bit <= pwdata[CSR_OSS_BIT];
      strobe_irq_on     <= pwdata[CSR_IRQ_BIT];
    end
  end

  wire logic latch_take = single && latch_enable && strobe_fall && !latch_held;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      strobe_in_q <= 1'b1;
      latch_held  <= 1'b0;
      latch_data  <= '0;
    end
    else if (clk_en)
    begin
      strobe_in_q <= strobe_ctl_first_in;
      if (latch_take)
      begin
        latch_held <= 1'b1;
        latch_data <= port_in;
      end
      else if (rd_data || !latch_enable || !single)
        latch_held <= 1'b0;
    end
  end

  // a new strobe edge in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      strobe_seen_flag <= 1'b0;
      flag_armed       <= 1'b0;
    end
    else if (clk_en)
    begin
      if (strobe_fall)
        strobe_seen_flag <= 1'b1;
      else if (flag_armed && acc_data)
        strobe_seen_flag <= 1'b0;
      if (rd_csr && strobe_seen_flag)
        flag_armed <= 1'b1;
      else if (acc_data)
        flag_armed <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output strobe
  // ---------------------------------------------------------------
  wire logic os_fire = single && (strobe_select_bit ? wr_data : rd_data);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      os_count <= 3'h0;
    else if (clk_en)
    begin
      if (os_fire)
        os_count <= OS_LOW_CYCLES;
      else if (os_count != 3'h0)
        os_count <= os_count - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // expanded bus cycle, one bus clock period per transfer
  // ---------------------------------------------------------------
  bus_state_t       bus_state;
  bus_state_t       next_bus_state;
  logic [15:0]      bus_addr;
  logic             bus_write;
  logic [WIDTH-1:0] bus_wdata;

  wire logic bus_start = !single && ext_req && e_end;

  always_comb
  begin
    next_bus_state = bus_state;
    unique case (bus_state)
      BUS_IDLE: if (bus_start) next_bus_state = BUS_ADDR;
      BUS_ADDR: next_bus_state = BUS_GAP;
      BUS_GAP:  next_bus_state = BUS_DATA;
      BUS_DATA: if (e_end) next_bus_state = BUS_IDLE;
    endcase
  end

  wire logic bus_finish = (bus_state == BUS_DATA) && e_end;
  wire logic in_window  = (bus_addr >= IO_WIN_LO) && (bus_addr <= IO_WIN_HI);
  wire logic busy       = (bus_state != BUS_IDLE);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_state <= BUS_IDLE;
      bus_addr  <= 16'h0000;
      bus_write <= 1'b0;
      bus_wdata <= '0;
      ext_rdata <= '0;
      ext_done  <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_state <= next_bus_state;
      ext_done  <= bus_finish;
      if (bus_state == BUS_IDLE && bus_start)
      begin
        bus_addr  <= ext_addr;
        bus_write <= ext_write;
        bus_wdata <= ext_wdata;
      end
      if (bus_finish && !bus_write)
        ext_rdata <= port_in;
    end
  end

  // ---------------------------------------------------------------
  // pin drive per mode
  // ---------------------------------------------------------------
  wire logic drive_wdata = (bus_state == BUS_DATA) && bus_write;
  wire logic drive_addr  = !nonmux && (bus_state == BUS_ADDR);

  wire logic [WIDTH-1:0] next_port_out =
      single      ? data_out :
      drive_addr  ? bus_addr[WIDTH-1:0] : bus_wdata;
  // gap state drives nothing, so address and data never overlap
  wire logic [WIDTH-1:0] next_port_oe_n =
      single                    ? ~ddr :
      (drive_addr || drive_wdata) ? {WIDTH{1'b0}} : {WIDTH{1'b1}};

  wire logic next_first_out =
      single ? 1'b1 :
      nonmux ? !(busy && in_window) :
               drive_addr;
  wire logic next_first_oe_n = single;
  wire logic next_second_out =
      single ? (os_count <= 3'h1) && !os_fire :
               !(busy && bus_write);
  wire logic next_irq_n = !(single && strobe_irq_on && strobe_seen_flag);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      port_out               <= '0;
      port_oe_n              <= '1;
      strobe_ctl_first_out   <= 1'b1;
      strobe_ctl_first_oe_n  <= 1'b1;
      strobe_ctl_second_out  <= 1'b1;
      maskable_request_one_n <= 1'b1;
    end
    else if (clk_en)
    begin
      port_out               <= next_port_out;
      port_oe_n              <= next_port_oe_n;
      strobe_ctl_first_out   <= next_first_out;
      strobe_ctl_first_oe_n  <= next_first_oe_n;
      strobe_ctl_second_out  <= next_second_out;
      maskable_request_one_n <= next_irq_n;
    end
  end

endmodule // port3_strobed_parallel_port

// [port3_strobed_parallel_port_tb.sv]
// self-checking bench for the strobed parallel port
`timescale 1ns/100ps
module port3_strobed_parallel_port_tb;
  import port3_pkg::*;
  logic              clk_sys, rst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [2:0]        mpins, mode;
  logic              ext_req, ext_write, ext_done, e_clk, strobe_go;
  logic [15:0]       ext_addr;
  logic [7:0]        ext_wdata, ext_rdata, port_in, port_out, port_oe_n, line_data, wr_seen;
  logic [7:0]        r, d, a, b;
  logic              s1_in, s1_out, s1_oe_n, s2_out, irq_n, lo_seen, hi_seen;
  logic [32:0]       expq[$], extq[$];
  logic [15:0]       win [4];
  int                num_errors, checks_done, os_lows, i;
  integer            seed;

  port3_strobed_parallel_port #(.WIDTH(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_pin_zero(mpins[0]), .mode_pin_one(mpins[1]),
    .mode_pin_two(mpins[2]), .mode(mode), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_done(ext_done),
    .e_clk(e_clk), .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .strobe_ctl_first_in(s1_in), .strobe_ctl_first_out(s1_out),
    .strobe_ctl_first_oe_n(s1_oe_n), .strobe_ctl_second_out(s2_out),
    .maskable_request_one_n(irq_n));
  port3_peer peer (.clk_sys(clk_sys), .mode(mode), .e_clk(e_clk), .rw(s2_out),
    .port_oe_n(port_oe_n), .port_out(port_out), .line_data(line_data),
    .strobe_go(strobe_go), .port_in(port_in), .strobe_in(s1_in), .wr_seen(wr_seen));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // -----------------------------------------------
  // shared tasks
  // -----------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    num_errors++;
    $display("[ERR] %s expected answer seen none", nm);
    tally_and_finish();
  endtask
  task automatic do_reset(input logic [2:0] m);
    rst   <= 1'b1;
    mpins <= m;
    repeat (16) @(posedge clk_sys);
    rst   <= 1'b0;
    mpins <= ~m;
    @(posedge clk_sys);
  endtask
  task automatic apb(input logic wr, input logic [APB_AW-1:0] ad, input logic [7:0] dv,
                     input logic [32:0] x);
    int n;
    expq.push_back(x);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= {24'h000000, dv};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hang("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic ext(input logic wr, input logic [15:0] ad, input logic [7:0] dv);
    int n;
    extq.push_back({25'h0, dv});
    ext_req   <= 1'b1;
    ext_write <= wr;
    ext_addr  <= ad;
    ext_wdata <= dv;
    if (!wr)
      line_data <= dv;
    {lo_seen, hi_seen} = 2'b00;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      lo_seen |= s1_out === 1'b0;
      hi_seen |= s1_out === 1'b1;
    end
    while (ext_done !== 1'b1 && n < 40);
    if (n >= 40)
      hang("ext_done");
    ext_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic pulse();
    strobe_go <= 1'b1;
    @(posedge clk_sys);
    strobe_go <= 1'b0;
    repeat (14) @(posedge clk_sys);
  endtask
  // results are compared in the order they were requested
  always @(posedge clk_sys)
  begin
    if (s2_out === 1'b0)
      os_lows++;
    if (psel && penable && pready === 1'b1)
      chk("apb", expq.size() > 0 ? expq.pop_front() : '1, {pslverr, prdata});
    if (ext_done === 1'b1)
      chk("ext", extq.size() > 0 ? extq.pop_front() : '1,
          {25'h0, ext_write ? wr_seen : ext_rdata});
  end
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    {psel, penable, pwrite, ext_req, ext_write, strobe_go} = 6'h00;
    {paddr, pwdata, ext_addr, ext_wdata, line_data} = '0;
    mpins = MODE_SINGLE;
    {num_errors, checks_done, os_lows} = '0;
    seed = 76;
    win = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200};
    do_reset(MODE_SINGLE);
    apb(0, CSR_ADDR, 0, 0);
    apb(0, DDR_ADDR, 0, {25'h0, DDR_RESET});
    apb(0, MODE_ADDR, 0, {30'h0, MODE_SINGLE});
    apb(0, 10'h200, 0, 33'h100000000);
    chk("sc1 oe", 1, s1_oe_n);
    apb(1, CSR_ADDR, 8'hff, 0);
    apb(0, CSR_ADDR, 0, 33'h58);
    $display("test registers done");
    r = 8'($random(seed));
    d = 8'($random(seed));
    line_data <= 8'($random(seed));
    apb(1, DDR_ADDR, r, 0);
    apb(1, DATA_ADDR, d, 0);
    chk("oe", 8'(~r), port_oe_n);
    chk("out", d & r, port_out & r);
    for (i = 0; i < 2; i++)
    begin
      apb(1, CSR_ADDR, 8'(i << CSR_OSS_BIT), 0);
      os_lows = 0;
      apb(0, DATA_ADDR, 0, {25'h0, (d & r) | (line_data & ~r)});
      apb(1, DATA_ADDR, d, 0);
      repeat (2) @(posedge clk_sys);
      chk("os low", 4, os_lows);
    end
    $display("test direction and strobe done");
    a = 8'($random(seed));
    b = ~a;
    apb(1, DDR_ADDR, 0, 0);
    apb(1, CSR_ADDR, 8'h08, 0);
    line_data <= a;
    pulse();
    chk("irq off", 1, irq_n);
    apb(1, CSR_ADDR, 8'h48, 0);
    chk("irq on", 0, irq_n);
    line_data <= b;
    pulse();
    apb(0, DATA_ADDR, 0, {25'h0, a});
    apb(0, CSR_ADDR, 0, 33'hc8);
    apb(0, DATA_ADDR, 0, {25'h0, b});
    apb(0, CSR_ADDR, 0, 33'h48);
    chk("irq clr", 1, irq_n);
    $display("test latch and flag done");
    do_reset(MODE_NONMUX);
    apb(0, MODE_ADDR, 0, {30'h0, MODE_NONMUX});
    chk("sc1 oe", 0, s1_oe_n);
    chk("mode", MODE_NONMUX, mode);
    // frozen enable must hold the bus clock; two edges always flip it otherwise
    clk_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    a = {7'h0, e_clk};
    repeat (2) @(posedge clk_sys);
    chk("freeze", a, e_clk);
    clk_en <= 1'b1;
    @(posedge clk_sys);
    apb(1, CSR_ADDR, 8'h48, 0);
    pulse();
    chk("irq exp", 1, irq_n);
    for (i = 0; i < 4; i++)
    begin
      ext(i[0], win[i], 8'($random(seed)));
      chk("io sel", i == 1 || i == 2, lo_seen);
    end
    $display("test plain bus done");
    do_reset(3'h1);
    for (i = 0; i < 2; i++)
    begin
      ext(i[0], 16'h12ab + 16'(i), 8'($random(seed)));
      chk("as", 1, hi_seen);
    end
    $display("test muxed bus done");
    tally_and_finish();
  end
endmodule // port3_strobed_parallel_port_tb
